// ---- design/ecp_pkg.sv ----
// Purpose: constants and types of the path config bank
// Assumes: 8-bit register port, 25 MHz clock
// Notes: all config registers are write only
package ecp_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_PROT    = 8'h01;
    localparam logic [7:0] ADDR_WDK1    = 8'h02;
    localparam logic [7:0] ADDR_WDK2    = 8'h03;
    localparam logic [7:0] ADDR_WDK3    = 8'h04;
    localparam logic [7:0] ADDR_PCM     = 8'h06;
    localparam logic [7:0] ADDR_INTERRUPT_SOURCE_MASK  = 8'h07;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_PCM_OUTPUT_GLOBAL_CONFIG = 8'h30;
    localparam logic [7:0] ADDR_ENCODING_LAW_GLOBAL_CONFIG = 8'h3f;
    localparam logic [7:0] ADDR_CH_BASE = 8'h40;
    localparam logic [7:0] ADDR_CH_LAST = 8'h5f;

    // Key values
    localparam logic [7:0] WDOG_KEY1  = 8'haa;
    localparam logic [7:0] WDOG_KEY2  = 8'h99;
    localparam logic [7:0] WDOG_KEY3  = 8'h1d;
    localparam logic [7:0] UNLOCK_KEY = 8'h95;

    // Values after reset
    localparam logic [7:0] RST_PROT    = 8'h00;
    localparam logic [3:0] RST_PCM     = 4'h0;
    localparam logic [7:0] RST_PCM_OUTPUT_GLOBAL_CONFIG = 8'h03;
    localparam logic [3:0] RST_ENCODING_LAW_GLOBAL_CONFIG = 4'h0;
    localparam logic [7:0] RST_CHCTL   = 8'h00;
    localparam logic [6:0] RST_INTERRUPT_SOURCE_MASK  = 7'h7f;

    // Field positions and channel count
    localparam int WDOG_BIT   = 6;
    localparam int UNLOCK_BIT = 7;
    localparam int NUM_CH     = 32;

    // Watchdog window
    localparam longint WDOG_TIME_MS  = 2000;
    localparam longint CLK_PERIOD_NS = 40;
    localparam int WDOG_CYCLES =
        int'(WDOG_TIME_MS * 64'd1000000 / CLK_PERIOD_NS);

    typedef struct packed {
        logic sr_loop;
        logic rs_loop;
        logic r_bypass;
        logic s_bypass;
    } ecp_pcm_t;

    typedef struct packed {
        logic std_noise;
        logic noise_mode;
        logic so_att_en;
        logic so_att_lvl;
        logic ro_att_en;
        logic ro_att_lvl;
        logic dyn_sub;
        logic err_inv;
    } ecp_pcm_output_global_config_t;

    typedef struct packed {
        logic per_chan;
        logic g_fallback;
        logic g_near;
        logic g_far;
    } ecp_encoding_law_global_config_t;

    typedef struct packed {
        logic fallback;
        logic near_law;
        logic far_law;
        logic conv_off;
        logic freeze;
        logic nlp_off;
        logic chan_off;
        logic reg_only;
    } ecp_chctl_t;

    typedef struct packed {
        logic near_law;
        logic far_law;
        logic conv_off;
        logic freeze;
        logic nlp_off;
        logic bypass;
        logic so_att;
        logic ro_att;
    } ecp_chout_t;

    typedef struct packed {
        logic conv_off;
        logic freeze;
        logic nlp_off;
        logic chan_off;
    } ecp_ext_t;

endpackage : ecp_pkg

// ---- design/ecp_wdog.sv ----
// Purpose: watchdog key sequence and two second timer
// Assumes: key strobes are one cycle long
// Notes: wrong key restarts the sequence, timer keeps running
module ecp_wdog #(
    parameter int CYCLES = ecp_pkg::WDOG_CYCLES
) (
    input  wire logic       clk_i,    // Device clock
    input  wire logic       rst_n_i,  // Async reset, active low
    input  wire logic [2:0] key_wr_i, // Key register write strobes
    input  wire logic [7:0] data_i,   // Written key value
    output logic            ok_o,     // Sequence done pulse
    output logic            expire_o  // Window missed pulse
);
    import ecp_pkg::*;

    typedef enum logic [2:0] {
        WK_IDLE = 3'b001,
        WK_ONE  = 3'b010,
        WK_TWO  = 3'b100
    } ecp_wkst_t;

    ecp_wkst_t   st_reg;
    logic [31:0] cnt_reg;
    logic        done;
    logic        tmo;

    assign done = (st_reg == WK_TWO) && key_wr_i[2] && (data_i == WDOG_KEY3);
    assign tmo  = (cnt_reg == 32'(CYCLES - 1));

    // Sequence state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= WK_IDLE;
        end else if (tmo || done) begin
            st_reg <= WK_IDLE;
        end else if (|key_wr_i) begin
            unique case (st_reg)
                WK_IDLE: st_reg <= (key_wr_i[0] && data_i == WDOG_KEY1)
                                   ? WK_ONE : WK_IDLE;
                WK_ONE:  st_reg <= (key_wr_i[1] && data_i == WDOG_KEY2)
                                   ? WK_TWO : WK_IDLE;
                WK_TWO:  st_reg <= WK_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= 32'h0;
            ok_o     <= 1'b0;
            expire_o <= 1'b0;
        end else begin
            cnt_reg  <= (tmo || done) ? 32'h0 : cnt_reg + 32'h1;
            ok_o     <= done;
            expire_o <= tmo;
        end
    end

    a_key_needs_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        key_wr_i[2] && st_reg != WK_TWO |=> !ok_o)
        else $error("watchdog accepted key three out of order");

    a_timer_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cnt_reg < 32'(CYCLES))
        else $error("watchdog timer ran past its window");

endmodule // ecp_wdog

// ---- design/ecp_chan.sv ----
// Purpose: resolve one channel's effective controls and laws
// Assumes: external control bits synchronous to the clock
// Notes: outputs registered, one cycle after any change
module ecp_chan (
    input  wire logic                  clk_i,   // Device clock
    input  wire logic                  rst_n_i, // Async reset, active low
    input  wire ecp_pkg::ecp_chctl_t   ctl_i,   // Channel register
    input  wire ecp_pkg::ecp_encoding_law_global_config_t law_i,   // Global law register
    input  wire ecp_pkg::ecp_ext_t     ext_i,   // External sources
    input  wire logic                  so_en_i, // Send atten enable
    input  wire logic                  ro_en_i, // Receive atten enable
    output ecp_pkg::ecp_chout_t        out_o    // Effective controls
);
    import ecp_pkg::*;

    ecp_ext_t   eff;
    ecp_chout_t nxt;

    assign eff = ctl_i.reg_only ? '0 : ext_i;

    always_comb begin
        nxt          = '0;
        nxt.conv_off = ctl_i.conv_off | eff.conv_off;
        nxt.freeze   = ctl_i.freeze | eff.freeze;
        nxt.nlp_off  = ctl_i.nlp_off | eff.nlp_off;
        nxt.bypass   = ctl_i.chan_off | eff.chan_off;
        if (law_i.per_chan) begin
            nxt.near_law = nxt.conv_off ? ctl_i.fallback : ctl_i.near_law;
            nxt.far_law  = nxt.conv_off ? ctl_i.fallback : ctl_i.far_law;
        end else begin
            nxt.near_law = nxt.conv_off ? law_i.g_fallback : law_i.g_near;
            nxt.far_law  = nxt.conv_off ? law_i.g_fallback : law_i.g_far;
        end
        nxt.so_att = so_en_i & ~nxt.bypass;
        nxt.ro_att = ro_en_i & ~nxt.bypass;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_o <= '0;
        end else begin
            out_o <= nxt;
        end
    end

endmodule // ecp_chan

// ---- design/ecp_top.sv ----
// Purpose: write-only configuration bank of the echo canceller
// Assumes: one-cycle strobes, read data valid the cycle after
// Notes: only the status register reads back non-zero
//
// Added by the designer: the plain strobed port.
module ecp_top #(
    parameter int WDOG_CYCLES = ecp_pkg::WDOG_CYCLES
) (
    input  wire logic                  MCLK_I,        // 25 MHz clock
    input  wire logic                  RSTN_I,        // Async reset, low
    input  wire logic [7:0]            ADDR_I,        // Register address
    input  wire logic [7:0]            WDATA_I,       // Write data
    input  wire logic                  WR_I,          // Write strobe
    input  wire logic                  RD_I,          // Read strobe
    input  wire logic [5:0]            IRQ_SRC_I,     // Event sources
    input  wire ecp_pkg::ecp_ext_t [31:0] EXT_I,      // External controls
    output logic [7:0]                 RDATA_O,       // Read data
    output logic                       IRQ_O,         // Interrupt, high
    output ecp_pkg::ecp_pcm_t          PCM_O,         // Loop and bypass
    output ecp_pkg::ecp_pcm_output_global_config_t      CONF_O,        // Output config
    output ecp_pkg::ecp_chout_t [31:0] CH_O           // Channel controls
);
    import ecp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0]   prot_reg;
    ecp_pcm_t     pcm_reg;
    ecp_pcm_output_global_config_t pcm_output_global_config_reg;
    ecp_encoding_law_global_config_t encoding_law_global_config_reg;
    logic [6:0]   interrupt_source_mask_reg;
    ecp_chctl_t   chctl_reg [NUM_CH];
    logic         wdog_flag_reg;
    logic [7:0]   rdata_reg;
    logic         irq_reg;
    ecp_pcm_t     pcm_out_reg;
    ecp_pcm_output_global_config_t conf_out_reg;

    logic         unlocked;
    logic         wr_prot;
    logic         ch_hit;
    logic [4:0]   ch_idx;
    logic [7:0]   ch_off;
    logic [6:0]   status;
    logic [2:0]   key_wr;
    logic         wd_ok;
    logic         wd_expire;
    logic         stat_rd;
    logic [7:0]   rdata_next;
    logic         irq_next;

    ////////////////////////////////////////////////////////////////////
    // Address decode

    assign unlocked = (prot_reg == UNLOCK_KEY);
    assign wr_prot  = WR_I && unlocked;

    assign ch_hit = (ADDR_I >= ADDR_CH_BASE) && (ADDR_I <= ADDR_CH_LAST);
    assign ch_off = ADDR_I - ADDR_CH_BASE;
    assign ch_idx = ch_off[4:0];

    // Key strobes, not protected
    assign key_wr = {WR_I && ADDR_I == ADDR_WDK3,
                     WR_I && ADDR_I == ADDR_WDK2,
                     WR_I && ADDR_I == ADDR_WDK1};

    assign stat_rd = RD_I && (ADDR_I == ADDR_STATUS);

    ////////////////////////////////////////////////////////////////////
    // Protection register

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prot_reg <= RST_PROT;
        end else if (WR_I && ADDR_I == ADDR_PROT) begin
            prot_reg <= WDATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Global configuration registers

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pcm_reg <= RST_PCM;
        end else if (wr_prot && ADDR_I == ADDR_PCM) begin
            pcm_reg <= WDATA_I[3:0];
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pcm_output_global_config_reg <= RST_PCM_OUTPUT_GLOBAL_CONFIG;
        end else if (wr_prot && ADDR_I == ADDR_PCM_OUTPUT_GLOBAL_CONFIG) begin
            pcm_output_global_config_reg <= WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            encoding_law_global_config_reg <= RST_ENCODING_LAW_GLOBAL_CONFIG;
        end else if (wr_prot && ADDR_I == ADDR_ENCODING_LAW_GLOBAL_CONFIG) begin
            encoding_law_global_config_reg <= WDATA_I[3:0];
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            interrupt_source_mask_reg <= RST_INTERRUPT_SOURCE_MASK;
        end else if (WR_I && ADDR_I == ADDR_INTERRUPT_SOURCE_MASK) begin
            interrupt_source_mask_reg <= WDATA_I[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Channel registers

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chctl_reg[i] <= RST_CHCTL;
            end
        end else if (wr_prot && ch_hit) begin
            chctl_reg[ch_idx] <= WDATA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog

    ecp_wdog #(
        .CYCLES   (WDOG_CYCLES)
    ) u_wdog (
        .clk_i    (MCLK_I),
        .rst_n_i  (RSTN_I),
        .key_wr_i (key_wr),
        .data_i   (WDATA_I),
        .ok_o     (wd_ok),
        .expire_o (wd_expire)
    );

    // sticky flag, set beats read clear
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wdog_flag_reg <= 1'b0;
        end else if (wd_expire) begin
            wdog_flag_reg <= 1'b1;
        end else if (stat_rd) begin
            wdog_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status, interrupt and read data

    assign status = {wdog_flag_reg, IRQ_SRC_I};

    assign irq_next = |(status & ~interrupt_source_mask_reg);

    // Read answer, status only
    always_comb begin
        rdata_next = 8'h00;
        if (stat_rd) begin
            rdata_next = {unlocked, status};
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_reg <= 8'h00;
            irq_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            irq_reg   <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Path outputs

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pcm_out_reg  <= RST_PCM;
            conf_out_reg <= RST_PCM_OUTPUT_GLOBAL_CONFIG;
        end else begin
            pcm_out_reg         <= pcm_reg;
            pcm_out_reg.sr_loop <= pcm_reg.sr_loop & ~pcm_reg.rs_loop;
            conf_out_reg        <= pcm_output_global_config_reg;
        end
    end

    assign RDATA_O = rdata_reg;
    assign IRQ_O   = irq_reg;
    assign PCM_O   = pcm_out_reg;
    assign CONF_O  = conf_out_reg;

    ////////////////////////////////////////////////////////////////////
    // Channel resolvers

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        ecp_chan u_chan (
            .clk_i   (MCLK_I),
            .rst_n_i (RSTN_I),
            .ctl_i   (chctl_reg[c]),
            .law_i   (encoding_law_global_config_reg),
            .ext_i   (EXT_I[c]),
            .so_en_i (pcm_output_global_config_reg.so_att_en),
            .ro_en_i (pcm_output_global_config_reg.ro_att_en),
            .out_o   (CH_O[c])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RSTN_I);

    a_mask_blocks_irq: assert property (
        (status & ~interrupt_source_mask_reg) == 7'h00 |=> !IRQ_O)
        else $error("masked source raised the interrupt");

    a_wdog_sets_flag: assert property (
        wd_expire |=> wdog_flag_reg ##1 (IRQ_O || interrupt_source_mask_reg[WDOG_BIT]))
        else $error("watchdog expiry not flagged");

    a_loop_priority: assert property (
        pcm_reg.sr_loop && pcm_reg.rs_loop |=> PCM_O.rs_loop && !PCM_O.sr_loop)
        else $error("send-to-receive loop active with both set");

    a_locked_write: assert property (
        WR_I && !unlocked && ADDR_I == ADDR_PCM_OUTPUT_GLOBAL_CONFIG
        |=> $stable(pcm_output_global_config_reg))
        else $error("protected register written while locked");

    a_unlock_write: assert property (
        WR_I && ADDR_I == ADDR_PROT && WDATA_I == UNLOCK_KEY
        ##1 WR_I && ADDR_I == ADDR_PCM
        |=> pcm_reg == $past(WDATA_I[3:0]))
        else $error("write after unlock not taken");

    a_atten_off: assert property (
        !pcm_output_global_config_reg.so_att_en |=> CH_O[0].so_att == 1'b0)
        else $error("send attenuation on while disabled");

    a_freeze_chan: assert property (
        chctl_reg[3].freeze |=> CH_O[3].freeze)
        else $error("channel freeze not applied");

    a_disable_bypass: assert property (
        chctl_reg[5].chan_off |=> CH_O[5].bypass && !CH_O[5].ro_att)
        else $error("disabled channel not bypassed");

    a_global_law: assert property (
        !encoding_law_global_config_reg.per_chan && !CH_O[1].conv_off ##1 $stable(encoding_law_global_config_reg)
        |-> CH_O[1].near_law == encoding_law_global_config_reg.g_near)
        else $error("global near law not applied");

    a_fallback_law: assert property (
        encoding_law_global_config_reg.per_chan && chctl_reg[2].conv_off
        |=> CH_O[2].far_law == $past(chctl_reg[2].fallback))
        else $error("channel fallback law not applied");

    a_reg_only: assert property (
        chctl_reg[4] == 8'h01 |=> !CH_O[4].bypass && !CH_O[4].freeze)
        else $error("external source acted on register-only channel");

    c_unlock_seen: cover property (
        WR_I && ADDR_I == ADDR_PROT && WDATA_I == UNLOCK_KEY);

    c_wdog_ok: cover property (wd_ok);

    c_wdog_expire: cover property (wd_expire ##1 IRQ_O);

    c_status_read: cover property (stat_rd ##1 RDATA_O != 8'h00);

endmodule // ecp_top

// ---- sim/ecp_top_tb.sv ----
// Purpose: self-checking bench of the path config bank
// Assumes: watchdog window shortened to 64 cycles
// Notes: bench drives every port itself, no partner model

`define CHK(what, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("wrong value %s exp %h got %h", what, e, g); \
        end \
    end

module ecp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ecp_pkg::*;

    localparam int WD = 64;

    logic              MCLK_I    = 1'b0;
    logic              RSTN_I    = 1'b0;
    logic [7:0]        ADDR_I    = 8'h00;
    logic [7:0]        WDATA_I   = 8'h00;
    logic              WR_I      = 1'b0;
    logic              RD_I      = 1'b0;
    logic [5:0]        IRQ_SRC_I = 6'h00;
    ecp_ext_t [31:0]   EXT_I     = '0;
    logic [7:0]        RDATA_O;
    logic              IRQ_O;
    ecp_pcm_t          PCM_O;
    ecp_pcm_output_global_config_t      CONF_O;
    ecp_chout_t [31:0] CH_O;
    int                n_mismatch = 0;
    int                checked    = 0;
    longint            cyc        = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and cycle count
    always #20 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) cyc <= cyc + 1;

    ecp_top #(.WDOG_CYCLES(WD)) i_ecp_top (
        .MCLK_I    (MCLK_I),
        .RSTN_I    (RSTN_I),
        .ADDR_I    (ADDR_I),
        .WDATA_I   (WDATA_I),
        .WR_I      (WR_I),
        .RD_I      (RD_I),
        .IRQ_SRC_I (IRQ_SRC_I),
        .EXT_I     (EXT_I),
        .RDATA_O   (RDATA_O),
        .IRQ_O     (IRQ_O),
        .PCM_O     (PCM_O),
        .CONF_O    (CONF_O),
        .CH_O      (CH_O)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK_I);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge MCLK_I);
        WR_I    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK_I);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        @(posedge MCLK_I);
        RD_I   <= 1'b0;
        #1 d = RDATA_O;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask

    // Closing report and verdict
    task automatic report_and_stop();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (IRQ_O !== 1'b1 && n < 300) begin
            @(posedge MCLK_I);
            #1;
            n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    // Expected channel controls: ctl, law config, ext, atten enables
    function automatic logic [7:0] exp_ch(input logic [7:0] c,
                                          input logic [3:0] l,
                                          input logic [3:0] x,
                                          input logic       so,
                                          input logic       ro);
        logic [3:0] e;
        logic [1:0] nf;
        e = c[4:1] | (c[0] ? 4'h0 : x);
        if (l[3])
            nf = e[3] ? {2{c[7]}} : c[6:5];
        else
            nf = e[3] ? {2{l[2]}} : l[1:0];
        return {nf, e, so & ~e[0], ro & ~e[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin : main
        logic [7:0] d;
        logic [7:0] e8;
        logic [7:0] conf;
        logic [7:0] ctl [32];
        longint     t0;
        repeat (5) @(posedge MCLK_I);
        RSTN_I <= 1'b1;
        tick(1);
        `CHK("pcm reset", 4'h0, PCM_O)
        `CHK("conf reset", 8'h03, CONF_O)
        `CHK("chan reset", 256'h0, CH_O)
        `CHK("irq reset", 1'b0, IRQ_O)
        $display("test reset done");

        // Locked writes ignored, then unlock
        wr(ADDR_PCM, 8'h0f);
        tick(3);
        `CHK("pcm locked", 4'h0, PCM_O)
        wr(8'hf0, 8'h95);
        wr(ADDR_PROT, UNLOCK_KEY);
        rd(ADDR_STATUS, d);
        `CHK("status unlock", 1'b1, d[7])
        rd(ADDR_PCM_OUTPUT_GLOBAL_CONFIG, d);
        `CHK("write only read", 8'h00, d)
        $display("test protect done");

        // Every loop and bypass setting
        for (int v = 0; v < 16; v++) begin
            wr(ADDR_PCM, 8'(v));
            tick(2);
            e8 = v[2] ? 8'(v) & 8'h07 : 8'(v);
            `CHK("pcm", e8[3:0], PCM_O)
        end
        $display("test loop done");

        // Channel registers over all law configs
        for (int i = 0; i < 32; i++) begin
            ctl[i] = 8'(i * 37 + 5);
            EXT_I[i] <= 4'(i * 7 + 3);
            wr(ADDR_CH_BASE + 8'(i), ctl[i]);
        end
        for (int j = 0; j < 2; j++) begin
            conf = j ? 8'h5a : 8'ha5;
            wr(ADDR_PCM_OUTPUT_GLOBAL_CONFIG, conf);
            tick(2);
            `CHK("conf", conf, CONF_O)
            for (int l = 0; l < 16; l++) begin
                wr(ADDR_ENCODING_LAW_GLOBAL_CONFIG, 8'(l));
                tick(3);
                for (int i = 0; i < 32; i++) begin
                    e8 = exp_ch(ctl[i], 4'(l), EXT_I[i], conf[5], conf[3]);
                    `CHK("chan", e8, CH_O[i])
                    `CHK("chan", e8, CH_O[i])
                    `CHK("chan", e8, CH_O[i])
                end
            end
        end
        $display("test channel done");

        // Relock, writes refused again
        wr(ADDR_PROT, 8'h00);
        wr(ADDR_CH_BASE, 8'hff);
        wr(ADDR_PCM, 8'h00);
        tick(3);
        e8 = exp_ch(ctl[0], 4'hf, EXT_I[0], 1'b0, 1'b1);
        `CHK("relock chan", e8, CH_O[0])
        `CHK("relock pcm", 4'h7, PCM_O)
        $display("test relock done");

        // Each event source unmasked then masked
        wr(ADDR_INTERRUPT_SOURCE_MASK, 8'h7f);
        for (int i = 0; i < 6; i++) begin
            IRQ_SRC_I <= 6'(1 << i);
            wr(ADDR_INTERRUPT_SOURCE_MASK, 8'h7f & ~8'(1 << i));
            tick(2);
            `CHK("irq unmasked", 1'b1, IRQ_O)
            rd(ADDR_STATUS, d);
            `CHK("status src", 6'(1 << i), d[5:0])
            wr(ADDR_INTERRUPT_SOURCE_MASK, 8'h7f);
            tick(2);
            `CHK("irq masked", 1'b0, IRQ_O)
        end
        IRQ_SRC_I <= 6'h00;
        $display("test sources done");

        // Mid-run reset so the watchdog window starts from a known edge
        @(posedge MCLK_I);
        RSTN_I <= 1'b0;
        repeat (2) @(posedge MCLK_I);
        RSTN_I <= 1'b1;
        tick(1);
        `CHK("pcm rereset", 4'h0, PCM_O)
        // Service, then a broken sequence must not restart the window
        wr(ADDR_WDK1, WDOG_KEY1);
        wr(ADDR_WDK2, WDOG_KEY2);
        wr(ADDR_WDK3, WDOG_KEY3);
        t0 = cyc;
        rd(ADDR_STATUS, d);
        wr(ADDR_INTERRUPT_SOURCE_MASK, 8'h00);
        tick(20);
        `CHK("wdog early", 1'b0, IRQ_O)
        wr(ADDR_WDK1, WDOG_KEY1);
        wr(ADDR_WDK2, WDOG_KEY2);
        wr(ADDR_WDK3, 8'h1e);
        wait_irq();
        `CHK("wdog time", 1'b1, (cyc - t0 >= 62 && cyc - t0 <= 72))
        rd(ADDR_STATUS, d);
        `CHK("wdog flag", 1'b1, d[6])
        tick(2);
        `CHK("irq cleared", 1'b0, IRQ_O)
        wr(ADDR_INTERRUPT_SOURCE_MASK, 8'h40);
        tick(100);
        `CHK("wdog masked", 1'b0, IRQ_O)
        rd(ADDR_STATUS, d);
        `CHK("flag masked", 1'b1, d[6])
        $display("test watchdog done");
        report_and_stop();
    end

endmodule // ecp_top_tb
